// >>> design/etsr_records.sv
// Fourth and fifth event timestamp sample records with register read port
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
// Overview of operation
// - Nanosecond and seconds records show the unit chosen by index pointer bit 8.
// - Bit 30 of each nanoseconds record is 1 for rising, 0 for falling.
// - Fourth nanoseconds record holds ns in bits 29:0, bit 31 zero.
// - Fifth nanoseconds record holds ns in bits 29:0, bit 31 zero.
// - Fourth seconds record holds 32 bits of seconds.
// - Fifth seconds record holds 32 bits of seconds.
// - Fourth phase record holds slot in bits 2:0, upper bits zero.
// - Fifth phase record holds slot in bits 2:0.
// - Slot codes: 000=0ns, 001=8ns, 011=24ns, 100=32ns.
// - The 16 ns slot uses code 010, not the misprinted 101.
// - Each 40 ns reference period splits into five 8 ns slots.
module etsr_records
   import etsr_pkg::*;
#(
   parameter int UNITS = 2
)
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [31:0] unit_index,
   input wire etsr_capture_t [UNITS-1:0] cap4,
   input wire etsr_capture_t [UNITS-1:0] cap5
);

   // One-hot register hit, decoded apart from the data path
   typedef struct packed {
      logic s4_ns;
      logic s4_sec;
      logic s4_slot;
      logic s5_ns;
      logic s5_sec;
      logic s5_slot;
   } etsr_hit_t;

   etsr_state_t st_q;
   etsr_state_t st_d;
   logic unit_sel;
   etsr_hit_t hit;
   etsr_sample_t u0_s4;
   etsr_sample_t u0_s5;
   etsr_sample_t u1_s4;
   etsr_sample_t u1_s5;
   etsr_sample_t cur4;
   etsr_sample_t cur5;
   logic [31:0] word_s4_ns;
   logic [31:0] word_s4_sec;
   logic [31:0] word_s4_slot;
   logic [31:0] word_s5_ns;
   logic [31:0] word_s5_sec;
   logic [31:0] word_s5_slot;
   logic [31:0] rd_word;

   // Slot index 0..4 to code; out-of-range index clamps to last slot
   function automatic logic [2:0] slot_code(input logic [2:0] idx);
      logic [2:0] c;
      c = ETSR_SLOT_32NS;
      case (idx)
         3'h0:
         begin
            c = ETSR_SLOT_0NS;
         end
         3'h1:
         begin
            c = ETSR_SLOT_8NS;
         end
         3'h2:
         begin
            c = ETSR_SLOT_16NS;
         end
         3'h3:
         begin
            c = ETSR_SLOT_24NS;
         end
         3'h4:
         begin
            c = ETSR_SLOT_32NS;
         end
         default:
         begin
            // Reserved codes never leave the block
            c = ETSR_SLOT_32NS;
         end
      endcase
      return c;
   endfunction

   function automatic etsr_sample_t take(input etsr_capture_t c);
      etsr_sample_t s;
      s.rising = c.rising;
      s.nanosec = c.nanosec;
      s.seconds = c.seconds;
      s.slot = slot_code(c.slot_index);
      return s;
   endfunction

   function automatic logic [31:0] ns_word(input etsr_sample_t s);
      return {1'b0, s.rising, s.nanosec};
   endfunction

   function automatic logic [31:0] slot_word(input etsr_sample_t s);
      return {29'h0000000, s.slot};
   endfunction

   // Only two units are addressable through a single pointer bit
   assign unit_sel = (UNITS > 1) ? unit_index[ETSR_UNIT_PTR_BIT] : 1'b0;

   assign u0_s4 = st_q.rec[0][0];
   assign u0_s5 = st_q.rec[0][1];
   assign u1_s4 = st_q.rec[1][0];
   assign u1_s5 = st_q.rec[1][1];

   // Both samples follow the one pointer, so a unit is never mixed
   always_comb
   begin
      if (unit_sel)
      begin
         cur4 = u1_s4;
         cur5 = u1_s5;
      end
      else
      begin
         cur4 = u0_s4;
         cur5 = u0_s5;
      end
   end

   // Software view of each record of the selected unit
   always_comb
   begin
      word_s4_ns = ns_word(cur4);
      word_s4_sec = cur4.seconds;
      word_s4_slot = slot_word(cur4);
      word_s5_ns = ns_word(cur5);
      word_s5_sec = cur5.seconds;
      word_s5_slot = slot_word(cur5);
   end

   // Decode kept one-hot so the read mux stays a single level
   always_comb
   begin
      hit = '0;
      if (reg_addr == ETSR_OFS_S4_NS)
      begin
         hit.s4_ns = 1'b1;
      end
      else if (reg_addr == ETSR_OFS_S4_SEC)
      begin
         hit.s4_sec = 1'b1;
      end
      else if (reg_addr == ETSR_OFS_S4_SLOT)
      begin
         hit.s4_slot = 1'b1;
      end
      else if (reg_addr == ETSR_OFS_S5_NS)
      begin
         hit.s5_ns = 1'b1;
      end
      else if (reg_addr == ETSR_OFS_S5_SEC)
      begin
         hit.s5_sec = 1'b1;
      end
      else if (reg_addr == ETSR_OFS_S5_SLOT)
      begin
         hit.s5_slot = 1'b1;
      end
      else
      begin
         // Unmapped offsets read back as zero
         hit = '0;
      end
   end

   always_comb
   begin
      rd_word = ETSR_RESET_WORD;
      if (hit.s4_ns)
      begin
         rd_word = word_s4_ns;
      end
      else if (hit.s4_sec)
      begin
         rd_word = word_s4_sec;
      end
      else if (hit.s4_slot)
      begin
         rd_word = word_s4_slot;
      end
      else if (hit.s5_ns)
      begin
         rd_word = word_s5_ns;
      end
      else if (hit.s5_sec)
      begin
         rd_word = word_s5_sec;
      end
      else if (hit.s5_slot)
      begin
         rd_word = word_s5_slot;
      end
      else
      begin
         rd_word = ETSR_RESET_WORD;
      end
   end

   always_comb
   begin
      st_d = st_q;
      for (int u = 0; u < UNITS && u < 2; u++)
      begin
         // Whole record replaced in one edge, never a mix
         if (cap4[u].valid)
         begin
            st_d.rec[u][0] = take(cap4[u]);
         end
         if (cap5[u].valid)
         begin
            st_d.rec[u][1] = take(cap5[u]);
         end
      end
      // Reads only return data; writes are ignored, all records RO
      st_d.rdata = ETSR_RESET_WORD;
      if (reg_rd)
      begin
         st_d.rdata = rd_word;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign reg_rdata = st_q.rdata;

endmodule

// >>> design/etsr_pkg.sv
// Package for the event timestamp sample record block
package etsr_pkg;

   localparam logic [11:0] ETSR_OFS_S4_NS = 12'h578;
   localparam logic [11:0] ETSR_OFS_S4_SEC = 12'h57C;
   localparam logic [11:0] ETSR_OFS_S4_SLOT = 12'h580;
   localparam logic [11:0] ETSR_OFS_S5_NS = 12'h584;
   localparam logic [11:0] ETSR_OFS_S5_SEC = 12'h588;
   localparam logic [11:0] ETSR_OFS_S5_SLOT = 12'h58C;

   localparam int ETSR_EDGE_BIT = 30;
   localparam int ETSR_NS_W = 30;
   localparam int ETSR_SEC_W = 32;
   localparam int ETSR_SLOT_W = 3;
   localparam int ETSR_UNIT_PTR_BIT = 8;

   localparam int ETSR_REF_PERIOD_NS = 40;
   localparam int ETSR_SLOT_NS = 8;
   localparam int ETSR_SLOTS = ETSR_REF_PERIOD_NS / ETSR_SLOT_NS;

   localparam logic [2:0] ETSR_SLOT_0NS = 3'h0;
   localparam logic [2:0] ETSR_SLOT_8NS = 3'h1;
   localparam logic [2:0] ETSR_SLOT_16NS = 3'h2;
   localparam logic [2:0] ETSR_SLOT_24NS = 3'h3;
   localparam logic [2:0] ETSR_SLOT_32NS = 3'h4;

   localparam logic [31:0] ETSR_RESET_WORD = 32'h0000_0000;

   // One captured sample, everything software sees for it
   typedef struct packed {
      logic rising;
      logic [ETSR_NS_W-1:0] nanosec;
      logic [ETSR_SEC_W-1:0] seconds;
      logic [ETSR_SLOT_W-1:0] slot;
   } etsr_sample_t;

   // Capture strobe from the trigger logic
   typedef struct packed {
      logic valid;
      logic rising;
      logic [ETSR_NS_W-1:0] nanosec;
      logic [ETSR_SEC_W-1:0] seconds;
      logic [2:0] slot_index;
   } etsr_capture_t;

   typedef struct packed {
      etsr_sample_t [1:0][1:0] rec;
      logic [31:0] rdata;
   } etsr_state_t;

endpackage

// >>> testbench/etsr_records_props.sv
// Checker on the sample record read port
`timescale 1ns/100ps
module etsr_records_props
   import etsr_pkg::*;
#(
   parameter int UNITS = 2
)
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic [31:0] unit_index,
   input wire etsr_capture_t [UNITS-1:0] cap4,
   input wire etsr_capture_t [UNITS-1:0] cap5
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   rd_idle_a: assert property (!reg_rd |=> reg_rdata == 0) else $error("rdata idle");
   ns_top_a: assert property (reg_rd && reg_addr == ETSR_OFS_S4_NS |=> !reg_rdata[31]) else $error("bit31");
   slot_high_a: assert property (reg_rd && reg_addr == ETSR_OFS_S4_SLOT |=> reg_rdata[31:3] == 0)
      else $error("slot high");
   slot_range_a: assert property (reg_rd && reg_addr == ETSR_OFS_S5_SLOT |=> reg_rdata < 5)
      else $error("slot range");
   edge_ns_a: assert property (cap4[0].valid ##1 (reg_rd && reg_addr == ETSR_OFS_S4_NS && !unit_index[8])
      |=> reg_rdata == {1'b0, $past(cap4[0].rising, 2), $past(cap4[0].nanosec, 2)}) else $error("ns4");
   sec_four_a: assert property (cap4[0].valid ##1 (reg_rd && reg_addr == ETSR_OFS_S4_SEC && !unit_index[8])
      |=> reg_rdata == $past(cap4[0].seconds, 2)) else $error("sec4");
   sec_five_a: assert property (cap5[1].valid ##1 (reg_rd && reg_addr == ETSR_OFS_S5_SEC && unit_index[8])
      |=> reg_rdata == $past(cap5[1].seconds, 2)) else $error("sec5");
   slot_code_a: assert property (cap4[1].valid ##1 (reg_rd && reg_addr == ETSR_OFS_S4_SLOT && unit_index[8])
      |=> reg_rdata[2:0] == (($past(cap4[1].slot_index, 2) > 3'h4) ? 3'h4 : $past(cap4[1].slot_index, 2)))
      else $error("slot4");
endmodule

// >>> testbench/etsr_records_tb.sv
// Random read-back bench for the sample records
`timescale 1ns/100ps
module etsr_records_tb;
   import etsr_pkg::*;
   logic sys_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0;
   logic [11:0] reg_addr = 12'h0;
   logic [31:0] reg_wdata = 0, unit_index = 0, reg_rdata, r = 32'h0CA9, exp_v = 0;
   logic [31:0] m [2][2][3];
   etsr_capture_t [1:0] cap4 = '0, cap5 = '0;
   int n_mismatch = 0, tests_run = 0, k;
   always #25 sys_clk = ~sys_clk;
   etsr_records dut_u (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .unit_index, .cap4, .cap5);
   function automatic logic [31:0] nx(input logic [31:0] s);
      repeat (32) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
      return s;
   endfunction
   // Slot code is the slot number; indices past the fifth slot clamp to it
   function automatic logic [2:0] ex_slot(input logic [2:0] i);
      return (i > 3'h4) ? 3'h4 : i;
   endfunction
   function automatic etsr_capture_t cp(input logic [31:0] s, input bit en);
      return {s[0] & en, s[1], s[31:2], nx(s), s[6:4]};
   endfunction
   task automatic upd(input int s, input int u, input etsr_capture_t c);
      if (c.valid)
         m[s][u] = '{{1'b0, c.rising, c.nanosec}, c.seconds, {29'h0, ex_slot(c.slot_index)}};
   endtask
   task automatic end_sim;
      if (n_mismatch == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      m = '{default: 32'h0};
      repeat (5) @(posedge sys_clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 3000; i++)
      begin
         @(negedge sys_clk);
         tests_run++;
         if (reg_rdata !== exp_v)
         begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, reg_rdata, exp_v);
         end
         @(posedge sys_clk);
         // Old record is seen by a read that meets a capture
         k = int'(reg_addr - ETSR_OFS_S4_NS) / 4;
         exp_v = (reg_rd && k < 6) ? m[k / 3][unit_index[8]][k % 3] : 32'h0;
         upd(0, 0, cap4[0]);
         upd(0, 1, cap4[1]);
         upd(1, 0, cap5[0]);
         upd(1, 1, cap5[1]);
         r = nx(r);
         reg_rd <= r[0];
         reg_wr <= !r[0] && r[1];
         reg_addr <= ETSR_OFS_S4_NS + 12'(4 * (r[7:4] % 7));
         reg_wdata <= r;
         unit_index <= nx(r);
         // No captures at first, so reset values are read back
         for (int u = 0; u < 2; u++)
         begin
            r = nx(r);
            cap4[u] <= cp(r, i > 30);
            r = nx(r);
            cap5[u] <= cp(r, i > 30);
         end
      end
      end_sim();
   end
endmodule
bind etsr_records etsr_records_props #(.UNITS(UNITS)) props_u (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .unit_index, .cap4, .cap5);
